// file: rtl/iolm_line_filter.sv
`timescale 1ns/1ps
module iolm_line_filter #(
  parameter int unsigned N = 32
) (
  // clock and reset
  input wire logic   sys_clk,
  input wire logic   arst_n,
  // synchronised pin levels in, filtered levels out
  iolm_line_if.filt  lines
);

  logic [N-1:0] stage_reg;
  logic [N-1:0] level_reg;
  logic [N-1:0] level_next;
  logic [N-1:0] prev_reg;
  logic [1:0]   primed_reg;

  // a filtered line only moves once two samples agree; one-cycle spikes vanish
  always_comb begin
    level_next = (lines.filt_en & ((lines.raw ~^ stage_reg) & lines.raw))
               | (lines.filt_en & ~(lines.raw ~^ stage_reg) & level_reg)
               | (lines.filt_en & (lines.raw ~^ stage_reg) & ~lines.raw & {N{1'b0}})
               | (~lines.filt_en & lines.raw);
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage_reg <= '0;
      level_reg <= '0;
      prev_reg  <= '0;
    end else begin
      stage_reg <= lines.raw;
      level_reg <= level_next;
      prev_reg  <= level_reg;
    end
  end

  // the pipe holds reset zeros at first; changes stay hidden until it is full
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      primed_reg <= 2'h0;
    end else if (primed_reg != 2'h3) begin
      primed_reg <= primed_reg + 2'h1;
    end
  end

  assign lines.level   = level_reg;
  assign lines.changed = (primed_reg == 2'h3) ? (level_reg ^ prev_reg) : '0;

endmodule

// file: rtl/iolm_line_if.sv
`timescale 1ns/1ps
interface iolm_line_if #(
  parameter int unsigned N = 32
);
  logic [N-1:0] raw;
  logic [N-1:0] filt_en;
  logic [N-1:0] level;
  logic [N-1:0] changed;

  modport filt (
    input  raw,
    input  filt_en,
    output level,
    output changed
  );
  modport ctrl (
    output raw,
    output filt_en,
    input  level,
    input  changed
  );
endinterface

// file: rtl/iolm_pkg.sv
package iolm_pkg;

  localparam int unsigned MAX_LINES = 32;

  // register window
  localparam logic [31:0] WIN_BASE_DEF = 32'hFFFA0000;
  localparam int unsigned WIN_BITS     = 14;

  // register offsets inside the window
  localparam logic [13:0] OFS_PER_SET  = 14'h0000;
  localparam logic [13:0] OFS_PER_CLR  = 14'h0004;
  localparam logic [13:0] OFS_PER_STAT = 14'h0008;
  localparam logic [13:0] OFS_OE_SET   = 14'h0010;
  localparam logic [13:0] OFS_OE_CLR   = 14'h0014;
  localparam logic [13:0] OFS_OE_STAT  = 14'h0018;
  localparam logic [13:0] OFS_FLT_SET  = 14'h0020;
  localparam logic [13:0] OFS_FLT_CLR  = 14'h0024;
  localparam logic [13:0] OFS_FLT_STAT = 14'h0028;
  localparam logic [13:0] OFS_OUT_SET  = 14'h0030;
  localparam logic [13:0] OFS_OUT_CLR  = 14'h0034;
  localparam logic [13:0] OFS_OUT_STAT = 14'h0038;
  localparam logic [13:0] OFS_PIN_LVL  = 14'h003C;
  localparam logic [13:0] OFS_MD_SET   = 14'h0040;
  localparam logic [13:0] OFS_MD_CLR   = 14'h0044;
  localparam logic [13:0] OFS_MD_STAT  = 14'h0048;
  localparam logic [13:0] OFS_PU_SET   = 14'h0050;
  localparam logic [13:0] OFS_PU_CLR   = 14'h0054;
  localparam logic [13:0] OFS_PU_STAT  = 14'h0058;
  localparam logic [13:0] OFS_SELB_SET = 14'h0060;
  localparam logic [13:0] OFS_SELB_CLR = 14'h0064;
  localparam logic [13:0] OFS_SELB_STAT= 14'h0068;
  localparam logic [13:0] OFS_SYNC_OUT = 14'h0070;
  localparam logic [13:0] OFS_SYNC_SET = 14'h0074;
  localparam logic [13:0] OFS_SYNC_CLR = 14'h0078;
  localparam logic [13:0] OFS_SYNC_STAT= 14'h007C;
  localparam logic [13:0] OFS_CHG_STAT = 14'h0080;
  localparam logic [13:0] OFS_IRQ_MASK = 14'h0084;

  // reset values
  localparam logic [31:0] RST_ZERO   = 32'h00000000;
  localparam logic [31:0] RST_PULLUP = 32'hFFFFFFFF;

  localparam logic [7:0] PERIPH_ID_DEF = 8'h02;
  localparam int unsigned SYNC_STAGES  = 2;

endpackage

// file: rtl/iolm_top.sv
`timescale 1ns/1ps
module iolm_top #(
  parameter int unsigned N            = iolm_pkg::MAX_LINES,
  parameter logic [31:0] BASE_ADDR    = iolm_pkg::WIN_BASE_DEF,
  parameter logic [31:0] RESET_PERIPH = iolm_pkg::RST_ZERO,
  parameter logic [31:0] DATA_BUS_MAP = iolm_pkg::RST_ZERO,
  parameter bit          HAS_PERIPH_B = 1'b1,
  parameter logic [7:0]  PERIPH_ID    = iolm_pkg::PERIPH_ID_DEF
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         arst_n,
  // wishbone slave
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [31:0]  wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic [31:0]       wb_dat_o,
  output logic              wb_ack_o,
  // pins
  input  wire logic [N-1:0] pin_in,
  output logic [N-1:0]      pin_out,
  output logic [N-1:0]      pin_oe,
  output logic [N-1:0]      pin_pullup,
  // peripheral functions A and B
  input  wire logic [N-1:0] func_a_out,
  input  wire logic [N-1:0] func_a_oe,
  input  wire logic [N-1:0] func_b_out,
  input  wire logic [N-1:0] func_b_oe,
  output logic [N-1:0]      func_in,
  // system
  output logic              irq,
  output logic [7:0]        periph_id,
  output logic              wide_bus_ok
);

  //////////////////////////////////////////////////////////////////////////////
  // bus slave

  logic              ack_reg;
  logic [31:0]       rdata_reg;
  logic              req;
  logic              in_win;
  logic [13:0]       ofs;
  logic              wr_fire;
  logic              rd_fire;
  logic [N-1:0]      wbits;
  logic [31:0]       bytemask;
  logic [31:0]       rd_mux;

  assign req    = wb_cyc_i & wb_stb_i;
  assign in_win = (wb_adr_i[31:iolm_pkg::WIN_BITS] ==
                   BASE_ADDR[31:iolm_pkg::WIN_BITS]);
  assign ofs    = {wb_adr_i[13:2], 2'b00};

  // writes land on the ack edge, the same edge the master takes as done
  assign wr_fire = req & wb_we_i & ack_reg & in_win;
  assign rd_fire = req & ~wb_we_i & ack_reg & in_win;

  assign bytemask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                     {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wbits    = wb_dat_i[N-1:0] & bytemask[N-1:0];

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= iolm_pkg::RST_ZERO;
    end else if (req & ~ack_reg) begin
      rdata_reg <= in_win ? rd_mux : iolm_pkg::RST_ZERO;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  //////////////////////////////////////////////////////////////////////////////
  // configuration registers

  logic [N-1:0] per_reg;
  logic [N-1:0] oe_reg;
  logic [N-1:0] flt_reg;
  logic [N-1:0] out_reg;
  logic [N-1:0] md_reg;
  logic [N-1:0] pu_reg;
  logic [N-1:0] selb_reg;
  logic [N-1:0] sync_reg;
  logic [N-1:0] chg_reg;
  logic [N-1:0] mask_reg;
  logic [N-1:0] pin_lvl;

  // one pair of offsets, a one in the data sets or clears, a zero keeps
  function automatic logic [N-1:0] set_clr(
    input logic [N-1:0] cur,
    input logic [13:0]  set_ofs,
    input logic [13:0]  clr_ofs,
    input logic         fire,
    input logic [13:0]  at,
    input logic [N-1:0] bits
  );
    logic [N-1:0] res;
    res = cur;
    if (fire && at == set_ofs) begin
      res = cur | bits;
    end else if (fire && at == clr_ofs) begin
      res = cur & ~bits;
    end
    return res;
  endfunction

  // memory-control lines leave reset in peripheral mode, others as inputs
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      per_reg <= RESET_PERIPH[N-1:0];
    end else begin
      per_reg <= set_clr(per_reg, iolm_pkg::OFS_PER_SET, iolm_pkg::OFS_PER_CLR,
                         wr_fire, ofs, wbits);
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      oe_reg <= iolm_pkg::RST_ZERO[N-1:0];
    end else begin
      oe_reg <= set_clr(oe_reg, iolm_pkg::OFS_OE_SET, iolm_pkg::OFS_OE_CLR,
                        wr_fire, ofs, wbits);
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      flt_reg <= iolm_pkg::RST_ZERO[N-1:0];
    end else begin
      flt_reg <= set_clr(flt_reg, iolm_pkg::OFS_FLT_SET, iolm_pkg::OFS_FLT_CLR,
                         wr_fire, ofs, wbits);
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      md_reg <= iolm_pkg::RST_ZERO[N-1:0];
    end else begin
      md_reg <= set_clr(md_reg, iolm_pkg::OFS_MD_SET, iolm_pkg::OFS_MD_CLR,
                        wr_fire, ofs, wbits);
    end
  end

  // pull-ups come out of reset enabled on every line
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pu_reg <= iolm_pkg::RST_PULLUP[N-1:0];
    end else begin
      pu_reg <= set_clr(pu_reg, iolm_pkg::OFS_PU_SET, iolm_pkg::OFS_PU_CLR,
                        wr_fire, ofs, wbits);
    end
  end

  // without a B function the selection stays at A and reads back as zero
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      selb_reg <= iolm_pkg::RST_ZERO[N-1:0];
    end else if (HAS_PERIPH_B) begin
      selb_reg <= set_clr(selb_reg, iolm_pkg::OFS_SELB_SET,
                          iolm_pkg::OFS_SELB_CLR, wr_fire, ofs, wbits);
    end else begin
      selb_reg <= iolm_pkg::RST_ZERO[N-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_reg <= iolm_pkg::RST_ZERO[N-1:0];
    end else begin
      sync_reg <= set_clr(sync_reg, iolm_pkg::OFS_SYNC_SET,
                          iolm_pkg::OFS_SYNC_CLR, wr_fire, ofs, wbits);
    end
  end

  // the synchronous write moves every enabled line on one edge
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_reg <= iolm_pkg::RST_ZERO[N-1:0];
    end else if (wr_fire && ofs == iolm_pkg::OFS_SYNC_OUT) begin
      out_reg <= (out_reg & ~(sync_reg & bytemask[N-1:0]))
               | (wb_dat_i[N-1:0] & sync_reg & bytemask[N-1:0]);
    end else begin
      out_reg <= set_clr(out_reg, iolm_pkg::OFS_OUT_SET, iolm_pkg::OFS_OUT_CLR,
                         wr_fire, ofs, wbits);
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_reg <= iolm_pkg::RST_ZERO[N-1:0];
    end else if (wr_fire && ofs == iolm_pkg::OFS_IRQ_MASK) begin
      mask_reg <= (mask_reg & ~bytemask[N-1:0]) | wbits;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin input path

  logic [N-1:0] meta_reg;
  logic [N-1:0] sync2_reg;

  // first stage feeds only the second
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg  <= iolm_pkg::RST_ZERO[N-1:0];
      sync2_reg <= iolm_pkg::RST_ZERO[N-1:0];
    end else begin
      meta_reg  <= pin_in;
      sync2_reg <= meta_reg;
    end
  end

  iolm_line_if #(.N(N)) lines_if ();

  assign lines_if.raw     = sync2_reg;
  assign lines_if.filt_en = flt_reg;

  iolm_line_filter #(
    .N (N)
  ) u_filter (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .lines   (lines_if.filt)
  );

  // pin level reads the unfiltered sampled pins, whatever the mode
  assign pin_lvl = sync2_reg;
  assign func_in = lines_if.level;

  //////////////////////////////////////////////////////////////////////////////
  // change status and interrupt

  logic [N-1:0] chg_clr;

  // a read of the status clears it; writing ones clears those bits too
  always_comb begin
    chg_clr = '0;
    if (rd_fire && ofs == iolm_pkg::OFS_CHG_STAT) begin
      chg_clr = rdata_reg[N-1:0];
    end else if (wr_fire && ofs == iolm_pkg::OFS_CHG_STAT) begin
      chg_clr = wbits;
    end
  end

  // new changes win over a clear in the same cycle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      chg_reg <= iolm_pkg::RST_ZERO[N-1:0];
    end else begin
      chg_reg <= (chg_reg & ~chg_clr) | lines_if.changed;
    end
  end

  assign irq = |(chg_reg & mask_reg);

  //////////////////////////////////////////////////////////////////////////////
  // pin drive

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_line
      logic drv_val;
      logic drv_en;

      always_comb begin
        if (per_reg[gi]) begin
          drv_val = selb_reg[gi] ? func_b_out[gi] : func_a_out[gi];
          drv_en  = selb_reg[gi] ? func_b_oe[gi]  : func_a_oe[gi];
        end else begin
          drv_val = out_reg[gi];
          drv_en  = oe_reg[gi];
        end
      end

      // open drain pulls low only; a high is left to the pull-up
      assign pin_out[gi]    = md_reg[gi] ? 1'b0 : drv_val;
      assign pin_oe[gi]     = md_reg[gi] ? (drv_en & ~drv_val) : drv_en;
      assign pin_pullup[gi] = pu_reg[gi];
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // read mux and system outputs

  always_comb begin
    rd_mux = iolm_pkg::RST_ZERO;
    case (ofs)
      iolm_pkg::OFS_PER_STAT:  rd_mux[N-1:0] = per_reg;
      iolm_pkg::OFS_OE_STAT:   rd_mux[N-1:0] = oe_reg;
      iolm_pkg::OFS_FLT_STAT:  rd_mux[N-1:0] = flt_reg;
      iolm_pkg::OFS_OUT_STAT:  rd_mux[N-1:0] = out_reg;
      iolm_pkg::OFS_PIN_LVL:   rd_mux[N-1:0] = pin_lvl;
      iolm_pkg::OFS_MD_STAT:   rd_mux[N-1:0] = md_reg;
      iolm_pkg::OFS_PU_STAT:   rd_mux[N-1:0] = pu_reg;
      iolm_pkg::OFS_SELB_STAT: rd_mux[N-1:0] = selb_reg;
      iolm_pkg::OFS_SYNC_STAT: rd_mux[N-1:0] = sync_reg;
      iolm_pkg::OFS_CHG_STAT:  rd_mux[N-1:0] = chg_reg;
      iolm_pkg::OFS_IRQ_MASK:  rd_mux[N-1:0] = mask_reg;
      default:                 rd_mux = iolm_pkg::RST_ZERO;
    endcase
  end

  assign periph_id = PERIPH_ID;

  // any data-bus line handed to gpio takes the upper half of the memory bus
  assign wide_bus_ok = &(per_reg | ~DATA_BUS_MAP[N-1:0]);

endmodule

// file: testbench/iolm_pins_model.sv
`timescale 1ns/1ps
module iolm_pins_model #(
  parameter int unsigned N = 32
) (
  // clock
  input  wire logic         sys_clk,
  // device pins
  input  wire logic [N-1:0] pin_out,
  input  wire logic [N-1:0] pin_oe,
  input  wire logic [N-1:0] pin_pullup,
  // board drivers
  input  wire logic [N-1:0] ext_en,
  input  wire logic [N-1:0] ext_lvl,
  output logic [N-1:0]      pin_in
);
  // a bare line flips every cycle so no stale level is mistaken for a real one
  logic [N-1:0] float_reg = '0;

  always_ff @(posedge sys_clk) float_reg <= ~float_reg;

  always_comb begin
    for (int i = 0; i < N; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_lvl[i];
      else if (pin_pullup[i]) pin_in[i] = 1'b1;
      else pin_in[i] = float_reg[i];
    end
  end
endmodule

// file: testbench/iolm_top_sva.sv
`timescale 1ns/1ps
module iolm_top_sva #(
  parameter int unsigned N            = 32,
  parameter logic [31:0] BASE_ADDR    = iolm_pkg::WIN_BASE_DEF,
  parameter logic [31:0] RESET_PERIPH = iolm_pkg::RST_ZERO,
  parameter logic [7:0]  PERIPH_ID    = iolm_pkg::PERIPH_ID_DEF
) (
  // clock, reset and bus
  input wire logic         sys_clk,
  input wire logic         arst_n,
  input wire logic         wb_cyc_i,
  input wire logic         wb_stb_i,
  input wire logic         wb_we_i,
  input wire logic [31:0]  wb_adr_i,
  input wire logic [31:0]  wb_dat_o,
  input wire logic         wb_ack_o,
  // pins and functions
  input wire logic [N-1:0] pin_in,
  input wire logic [N-1:0] pin_out,
  input wire logic [N-1:0] pin_oe,
  input wire logic [N-1:0] pin_pullup,
  input wire logic [N-1:0] func_a_out,
  input wire logic [N-1:0] func_a_oe,
  input wire logic [N-1:0] func_in,
  input wire logic [7:0]   periph_id
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  logic [3:0] up_cnt;
  wire        req_new = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire        lvl_rd  = req_new && !wb_we_i
                        && wb_adr_i == {BASE_ADDR[31:14], iolm_pkg::OFS_PIN_LVL};

  // cycles since reset, so pre-reset samples never feed the level checks
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) up_cnt <= 4'h0;
    else if (up_cnt != 4'hF) up_cnt <= up_cnt + 4'h1;
  end

  ////////////////////////////////////////////////////////////////
  chk_ack_after_req: assert property (req_new |=> wb_ack_o)
    else $error("no ack one cycle after request");
  chk_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  chk_outside_zero: assert property (req_new && !wb_we_i
    && wb_adr_i[31:14] != BASE_ADDR[31:14] |=> wb_dat_o == 32'h0)
    else $error("read outside window not zero");
  chk_data_holds: assert property (!wb_ack_o |-> $stable(wb_dat_o))
    else $error("read data moved without ack");
  chk_reset_pullup: assert property (up_cnt == 4'h0 |-> pin_pullup == '1)
    else $error("pull-ups not on after reset");
  chk_reset_drive: assert property (up_cnt == 4'h0 |-> pin_oe == (func_a_oe & RESET_PERIPH[N-1:0])
    && (pin_out & RESET_PERIPH[N-1:0]) == (func_a_out & RESET_PERIPH[N-1:0]))
    else $error("reset drive state wrong");
  chk_id_fixed: assert property (periph_id == PERIPH_ID)
    else $error("identifier wrong");
  chk_level_read: assert property ($stable(pin_in)[*4] ##0 (lvl_rd && up_cnt == 4'hF)
    |=> wb_dat_o[N-1:0] == $past(pin_in))
    else $error("pin level read wrong");
  chk_func_follows: assert property (up_cnt == 4'hF && $stable(pin_in)[*8]
    |-> func_in == pin_in)
    else $error("function input not following pin");
endmodule

bind iolm_top iolm_top_sva #(.N(N), .BASE_ADDR(BASE_ADDR), .RESET_PERIPH(RESET_PERIPH),
  .PERIPH_ID(PERIPH_ID)) u_sva (.sys_clk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_o, .wb_ack_o, .pin_in, .pin_out, .pin_oe, .pin_pullup,
  .func_a_out, .func_a_oe, .func_in, .periph_id);

// file: testbench/tb.sv
`timescale 1ns/1ps
module tb;
  localparam logic [31:0] RP = 32'h00000F00;
  localparam logic [31:0] DM = 32'hFFFF0000;
  localparam logic [31:0] BA = iolm_pkg::WIN_BASE_DEF;

  logic        sys_clk = 1'b0;
  logic        arst_n  = 1'b0;
  logic        req     = 1'b0;
  logic        we      = 1'b0;
  logic [31:0] adr     = 32'h0;
  logic [31:0] wdat    = 32'h0;
  logic [31:0] fa      = 32'hA5A55AA5;
  logic [31:0] fao     = 32'hFFFFFFFF;
  logic [31:0] fb      = 32'h3C3C3C3C;
  logic [31:0] fbo     = 32'h00010000;
  logic [31:0] xl      = 32'h55550000;
  logic [31:0] rdat, pout, poe, ppu, fin, pin, q;
  logic [7:0]  pid;
  logic        ack, irq, wok;
  int          err_total  = 0;
  int          num_checks = 0;

  always #10 sys_clk = ~sys_clk;

  iolm_top #(.RESET_PERIPH(RP), .DATA_BUS_MAP(DM), .PERIPH_ID(8'h04)) dut (
    .sys_clk, .arst_n, .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .pin_in(pin),
    .pin_out(pout), .pin_oe(poe), .pin_pullup(ppu), .func_a_out(fa), .func_a_oe(fao),
    .func_b_out(fb), .func_b_oe(fbo), .func_in(fin), .irq, .periph_id(pid),
    .wide_bus_ok(wok));

  iolm_pins_model u_pins (.sys_clk, .pin_out(pout), .pin_oe(poe), .pin_pullup(ppu),
    .ext_en(DM), .ext_lvl(xl), .pin_in(pin));

  ////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t got %h exp %h", $time, g, e);
    end
  endtask

  function automatic logic [31:0] ad(input logic [13:0] o);
    return {BA[31:14], o};
  endfunction

  // request held until the edge that samples ack, released only after it
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    logic got;
    got = 1'b0;
    @(posedge sys_clk);
    req  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    // ack and read data are taken at the rising edge that samples ack high
    repeat (50) begin
      @(posedge sys_clk);
      if (ack === 1'b1) begin
        got = 1'b1;
        r   = rdat;
        break;
      end
    end
    if (got !== 1'b1) begin
      err_total++;
      test_done();
    end
    req <= 1'b0;
    we  <= 1'b0;
    // outputs launched by the ack edge are settled by the falling edge
    @(negedge sys_clk);
  endtask

  task automatic wr(input logic [13:0] o, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, ad(o), d, r);
  endtask

  task automatic rc(input logic [13:0] o, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, ad(o), 32'h0, r);
    chk(r, e);
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge sys_clk);
    arst_n <= 1'b1;
    rc(iolm_pkg::OFS_PER_STAT, RP);
    rc(iolm_pkg::OFS_PU_STAT, 32'hFFFFFFFF);
    rc(iolm_pkg::OFS_OE_STAT, 32'h0);
    chk(poe, fao & RP);
    chk({24'h0, pid}, 32'h4);
    chk({31'h0, wok}, 32'h0);
    wr(iolm_pkg::OFS_OE_SET, 32'h000000FF);
    wr(iolm_pkg::OFS_OUT_SET, 32'h0000000F);
    wr(iolm_pkg::OFS_OUT_CLR, 32'h00000003);
    wr(iolm_pkg::OFS_OUT_STAT, 32'hFFFFFFFF);
    wr(iolm_pkg::OFS_SYNC_SET, 32'h000000F0);
    wr(iolm_pkg::OFS_SYNC_OUT, 32'hFFFFFF50);
    rc(iolm_pkg::OFS_SYNC_STAT, 32'h000000F0);
    rc(iolm_pkg::OFS_OUT_STAT, 32'h0000005C);
    chk(pout & 32'hFF, 32'h5C);
    wr(iolm_pkg::OFS_MD_SET, 32'h00000003);
    chk(poe & 32'h3, 32'h3);
    chk(pout & 32'h3, 32'h0);
    wr(iolm_pkg::OFS_OUT_SET, 32'h00000001);
    chk(poe & 32'h3, 32'h2);
    repeat (4) @(posedge sys_clk);
    rc(iolm_pkg::OFS_PIN_LVL, (xl & DM) | 32'h0000F000 | (fa & RP) | 32'h5D);
    wr(iolm_pkg::OFS_PU_CLR, 32'h80000000);
    chk(ppu, 32'h7FFFFFFF);
    rc(iolm_pkg::OFS_PU_STAT, 32'h7FFFFFFF);
    // change flags and the interrupt
    wr(iolm_pkg::OFS_IRQ_MASK, 32'h00010000);
    wb(1'b0, ad(iolm_pkg::OFS_CHG_STAT), 32'h0, q);
    @(posedge sys_clk);
    xl <= xl ^ 32'h00010000;
    repeat (20) begin
      @(negedge sys_clk);
      if (irq === 1'b1) break;
    end
    chk({31'h0, irq}, 32'h1);
    rc(iolm_pkg::OFS_CHG_STAT, 32'h00010000);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    xl <= xl ^ 32'h00020000;
    repeat (10) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    rc(iolm_pkg::OFS_CHG_STAT, 32'h00020000);
    // a one-cycle glitch must not pass the filter
    wr(iolm_pkg::OFS_FLT_SET, 32'h00010000);
    @(posedge sys_clk);
    xl <= xl ^ 32'h00010000;
    @(posedge sys_clk);
    xl <= xl ^ 32'h00010000;
    repeat (10) @(posedge sys_clk);
    rc(iolm_pkg::OFS_CHG_STAT, 32'h0);
    // peripheral selection on the upper lines
    wr(iolm_pkg::OFS_PER_SET, DM);
    chk({31'h0, wok}, 32'h1);
    wr(iolm_pkg::OFS_SELB_SET, 32'h00030000);
    chk(pout & DM, (fa & 32'hFFFC0000) | (fb & 32'h00030000));
    chk(poe & DM, (fao & 32'hFFFC0000) | (fbo & 32'h00030000));
    wr(iolm_pkg::OFS_PER_CLR, DM);
    chk(poe & DM, 32'h0);
    chk({31'h0, wok}, 32'h0);
    // accesses outside the window and at a hole
    wb(1'b1, ad(iolm_pkg::OFS_OUT_SET) + 32'h4000, 32'hFFFFFFFF, q);
    wb(1'b0, ad(iolm_pkg::OFS_OUT_STAT) + 32'h4000, 32'h0, q);
    chk(q, 32'h0);
    rc(14'h0100, 32'h0);
    rc(iolm_pkg::OFS_OUT_STAT, 32'h0000005D);
    test_done();
  end
endmodule
